//--- pnm_pkg.sv
// Package of constants and types for the auto-negotiation and MMD registers.
package pnm_pkg;

    // Register addresses on the management frame.
    localparam logic [4:0] REG_PARTNER_BASE = 5'h05;
    localparam logic [4:0] REG_EXPANSION = 5'h06;
    localparam logic [4:0] REG_LOCAL_NP = 5'h07;
    localparam logic [4:0] REG_PARTNER_NP = 5'h08;
    localparam logic [4:0] REG_MMD_CTRL = 5'h0d;
    localparam logic [4:0] REG_MMD_DATA = 5'h0e;

    // Management frame layout.
    localparam int PREAMBLE_BITS = 32;
    localparam int HEADER_BITS = 14;
    localparam int DATA_BITS = 16;
    localparam logic [1:0] FRAME_START = 2'h1;
    localparam logic [1:0] FRAME_OP_READ = 2'h2;
    localparam logic [1:0] FRAME_OP_WRITE = 2'h1;

    // Partner base page selector and expansion bit positions.
    localparam logic [4:0] SELECTOR_IEEE = 5'h01;
    localparam int EXP_PFAULT = 4;
    localparam int EXP_LP_NP_ABLE = 3;
    localparam int EXP_NP_ABLE = 2;
    localparam int EXP_PAGE_RX = 1;
    localparam int EXP_LP_AN_ABLE = 0;

    // Next page word fields.
    localparam int NP_MORE = 15;
    localparam int NP_ACK = 14;
    localparam int NP_MSG = 13;
    localparam int NP_ACK2 = 12;
    localparam int NP_TOGGLE = 11;
    localparam int NP_CODE_W = 11;
    localparam logic NP_MORE_RST = 1'h0;
    localparam logic NP_MSG_RST = 1'h1;
    localparam logic NP_ACK2_RST = 1'h0;
    localparam logic [10:0] NP_CODE_RST = 11'h001;

    // Indirect access control fields.
    localparam int MMD_OP_HI = 15;
    localparam int MMD_OP_LO = 14;
    localparam int MMD_DEV_W = 5;
    localparam logic [1:0] MMD_OP_ADDR = 2'h0;
    localparam logic [1:0] MMD_OP_DATA = 2'h1;
    localparam logic [1:0] MMD_OP_INC_RW = 2'h2;
    localparam logic [1:0] MMD_OP_INC_WR = 2'h3;

    typedef enum logic [2:0] {
        S_PRE,
        S_HDR,
        S_TA,
        S_RD,
        S_WR
    } pnm_phase_t;

endpackage : pnm_pkg

//--- pnm_pin_sync.sv
// Two-stage synchroniser for the management pins with clock edge detection.
`timescale 1ns/1ps
module pnm_pin_sync
    import pnm_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Raw pins.
    input wire logic mdc_pin,
    input wire logic mdio_pin,
    // Synchronised results.
    output logic mdc_rise,
    output logic mdio_s
);

    typedef struct packed {
        logic [1:0] mdc;
        logic [1:0] mdio;
        logic mdc_last;
    } pnm_sync_t;

    pnm_sync_t s_q;
    pnm_sync_t s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.mdc = {s_q.mdc[0], mdc_pin};
        s_d.mdio = {s_q.mdio[0], mdio_pin};
        // The edge detector looks only at the second stage.
        s_d.mdc_last = s_q.mdc[1];
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign mdc_rise = s_q.mdc[1] & ~s_q.mdc_last;
    assign mdio_s = s_q.mdio[1];

endmodule : pnm_pin_sync

//--- pnm_regs.sv
// Management register bank: expansion, next pages and indirect MMD window.
//
// Function
// - Partner base-page register returns selector 00001 in bits 4:0, read-only.
// - Expansion bit 4 latches high on a parallel detection fault, resets 0.
// - Expansion bit 3 shows partner next-page capability, follows lp_np_able, not reset.
// - Expansion bit 2 always reads 1: local next pages supported.
// - Expansion bit 1 latches high on a new received page, resets 0.
// - Expansion bit 0 shows partner auto-negotiation ability.
// - Local next-page bit 15 writable, more pages follow; resets 0.
// - Local next-page bit 12 writable, will-comply flag; resets 0.
// - Local next-page bit 11 read-only, previous transmitted toggle value.
// - Local bits 10:0 writable message code reset 001; bit 14 reads 0.
// - Partner next-page register read-only; bits 15, 14 more-pages, acknowledge.
// - Partner bits 13, 12 and 10:0 report message, ability, code.
// - Partner bit 11 reads inverse of previous transmitted toggle.
// - Operation 00 selects address mode, 01 data without increment.
// - Operation 10 increments indirect address after each data read or write.
// - Operation 11 increments indirect address after data writes only.
// - Control bits 4:0 hold device address reset 0; bits 13:5 reserved.
// - With operation 00 the data register holds the indirect address.
// - Otherwise the data register accesses selected device data.
`timescale 1ns/1ps
module pnm_regs
    import pnm_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h00
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Management pins.
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_n,
    // Auto-negotiation engine status.
    input wire logic parallel_fault_evt,
    input wire logic page_rx_evt,
    input wire logic lp_np_able,
    input wire logic lp_an_able,
    input wire logic tx_toggle,
    input wire logic [15:0] lp_np_word,
    // Next page word for the engine to send.
    output logic [15:0] np_tx_word,
    // Indirect device access.
    output logic [4:0] mmd_dev,
    output logic [15:0] mmd_reg,
    output logic [15:0] mmd_wdata,
    output logic mmd_wr,
    output logic mmd_rd,
    input wire logic [15:0] mmd_rdata
);

    typedef struct packed {
        pnm_phase_t phase;
        logic [5:0] cnt;
        logic [15:0] sh;
        logic is_rd;
        logic [4:0] regad;
        logic mdo;
        logic oe_n;
        logic pfault;
        logic pg_rx;
        logic np_more;
        logic np_msg;
        logic np_ack2;
        logic [10:0] np_code;
        logic [15:0] lp_word;
        logic [1:0] op;
        logic [4:0] dev;
        logic [15:0] mreg;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } pnm_state_t;

    pnm_state_t q;
    pnm_state_t d;
    logic mdc_rise;
    logic mdio_s;
    logic [15:0] hdr;
    logic [15:0] wword;
    logic hdr_done;
    logic hdr_ok;
    logic e_rd;
    logic e_wr;
    logic exp_rd;
    logic [15:0] rdata;

    pnm_pin_sync u_sync (
        .clk(clk),
        .reset(reset),
        .mdc_pin(mdc),
        .mdio_pin(mdio_in),
        .mdc_rise(mdc_rise),
        .mdio_s(mdio_s)
    );

    // Post-increment rule shared by read and write data accesses.
    function automatic logic incr_on(input logic [1:0] op, input logic is_wr);
        incr_on = (op == MMD_OP_INC_RW) || (is_wr && op == MMD_OP_INC_WR);
    endfunction : incr_on

    assign hdr = {q.sh[14:0], mdio_s};
    assign wword = hdr;
    assign hdr_done = mdc_rise && q.phase == S_HDR
        && q.cnt == 6'(HEADER_BITS - 1);
    assign hdr_ok = hdr[13:12] == FRAME_START && hdr[9:5] == PHY_ADDR;
    assign e_rd = hdr_done && hdr_ok && hdr[11:10] == FRAME_OP_READ;
    assign e_wr = mdc_rise && q.phase == S_WR && q.cnt == 6'(DATA_BITS - 1);
    assign exp_rd = e_rd && hdr[4:0] == REG_EXPANSION;

    // Read multiplexer, addressed by the register field of the header.
    always_comb
    begin
        rdata = '0;
        case (hdr[4:0])
            REG_PARTNER_BASE: rdata[4:0] = SELECTOR_IEEE;
            REG_EXPANSION:
            begin
                rdata[EXP_PFAULT] = q.pfault;
                rdata[EXP_LP_NP_ABLE] = lp_np_able;
                rdata[EXP_NP_ABLE] = 1'h1;
                rdata[EXP_PAGE_RX] = q.pg_rx;
                rdata[EXP_LP_AN_ABLE] = lp_an_able;
            end
            REG_LOCAL_NP: rdata = np_tx_word;
            REG_PARTNER_NP:
            begin
                rdata = q.lp_word;
                rdata[NP_TOGGLE] = ~tx_toggle;
            end
            REG_MMD_CTRL:
            begin
                rdata[MMD_OP_HI:MMD_OP_LO] = q.op;
                rdata[MMD_DEV_W-1:0] = q.dev;
            end
            REG_MMD_DATA:
            begin
                rdata = (q.op == MMD_OP_ADDR) ? q.mreg : mmd_rdata;
            end
            default: rdata = '0;
        endcase
    end

    always_comb
    begin
        d = q;
        d.wr = 1'h0;
        d.rd = 1'h0;
        // Sticky status: a new event wins over the clear by a read.
        d.pfault = (q.pfault & ~exp_rd) | parallel_fault_evt;
        d.pg_rx = (q.pg_rx & ~exp_rd) | page_rx_evt;
        if (page_rx_evt)
        begin
            d.lp_word = lp_np_word;
        end
        if (mdc_rise)
        begin
            case (q.phase)
                S_PRE:
                begin
                    if (mdio_s)
                    begin
                        if (q.cnt != 6'(PREAMBLE_BITS))
                        begin
                            d.cnt = q.cnt + 6'h01;
                        end
                    end
                    else if (q.cnt == 6'(PREAMBLE_BITS))
                    begin
                        d.phase = S_HDR;
                        d.cnt = 6'h01;
                        d.sh = '0;
                    end
                    else
                    begin
                        d.cnt = '0;
                    end
                end
                S_HDR:
                begin
                    d.sh = hdr;
                    d.cnt = q.cnt + 6'h01;
                    if (hdr_done)
                    begin
                        d.cnt = '0;
                        d.regad = hdr[4:0];
                        d.is_rd = e_rd;
                        d.phase = (hdr_ok && (hdr[11:10] == FRAME_OP_READ
                            || hdr[11:10] == FRAME_OP_WRITE)) ? S_TA : S_PRE;
                        if (e_rd)
                        begin
                            d.sh = rdata;
                        end
                    end
                end
                S_TA:
                begin
                    d.cnt = q.cnt + 6'h01;
                    if (q.is_rd)
                    begin
                        d.oe_n = 1'h0;
                        d.mdo = 1'h0;
                        d.phase = S_RD;
                        d.cnt = '0;
                    end
                    else if (q.cnt == 6'h01)
                    begin
                        d.phase = S_WR;
                        d.cnt = '0;
                    end
                end
                S_RD:
                begin
                    d.cnt = q.cnt + 6'h01;
                    if (q.cnt == 6'(DATA_BITS))
                    begin
                        d.oe_n = 1'h1;
                        d.mdo = 1'h0;
                        d.phase = S_PRE;
                        d.cnt = '0;
                    end
                    else
                    begin
                        d.mdo = q.sh[15];
                        d.sh = {q.sh[14:0], 1'h0};
                    end
                end
                S_WR:
                begin
                    d.sh = wword;
                    d.cnt = q.cnt + 6'h01;
                    if (e_wr)
                    begin
                        d.phase = S_PRE;
                        d.cnt = '0;
                    end
                end
                default:
                begin
                    d.phase = S_PRE;
                    d.cnt = '0;
                    d.oe_n = 1'h1;
                end
            endcase
        end
        // Indirect data reads are taken when the header completes.
        if (e_rd && hdr[4:0] == REG_MMD_DATA && q.op != MMD_OP_ADDR)
        begin
            d.rd = 1'h1;
            if (incr_on(q.op, 1'h0))
            begin
                d.mreg = q.mreg + 16'h0001;
            end
        end
        // The write pulse must leave with the address it targets.
        if (q.wr && incr_on(q.op, 1'h1))
        begin
            d.mreg = q.mreg + 16'h0001;
        end
        if (e_wr)
        begin
            case (q.regad)
                REG_LOCAL_NP:
                begin
                    d.np_more = wword[NP_MORE];
                    d.np_msg = wword[NP_MSG];
                    d.np_ack2 = wword[NP_ACK2];
                    d.np_code = wword[NP_CODE_W-1:0];
                end
                REG_MMD_CTRL:
                begin
                    d.op = wword[MMD_OP_HI:MMD_OP_LO];
                    d.dev = wword[MMD_DEV_W-1:0];
                end
                REG_MMD_DATA:
                begin
                    if (q.op == MMD_OP_ADDR)
                    begin
                        d.mreg = wword;
                    end
                    else
                    begin
                        d.wr = 1'h1;
                        d.wdata = wword;
                    end
                end
                default: d.op = q.op;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            q <= '0;
            q.phase <= S_PRE;
            q.oe_n <= 1'h1;
            q.np_more <= NP_MORE_RST;
            q.np_msg <= NP_MSG_RST;
            q.np_ack2 <= NP_ACK2_RST;
            q.np_code <= NP_CODE_RST;
            q.op <= MMD_OP_ADDR;
        end
        else
        begin
            q <= d;
        end
    end

    // Bit 14 reserved reads 0, bit 11 mirrors the transmitted toggle.
    assign np_tx_word = {q.np_more, 1'h0, q.np_msg, q.np_ack2, tx_toggle,
        q.np_code};
    assign mdio_out = q.mdo;
    assign mdio_oe_n = q.oe_n;
    assign mmd_dev = q.dev;
    assign mmd_reg = q.mreg;
    assign mmd_wdata = q.wdata;
    assign mmd_wr = q.wr;
    assign mmd_rd = q.rd;

    a_fault_latch: assert property (@(posedge clk) disable iff (reset)
        parallel_fault_evt |=> q.pfault)
        else $error("fault event not latched");
    a_page_latch: assert property (@(posedge clk) disable iff (reset)
        page_rx_evt |=> q.pg_rx)
        else $error("page event not latched");
    a_sticky_hold: assert property (@(posedge clk) disable iff (reset)
        q.pg_rx && !(e_rd && hdr[4:0] == REG_EXPANSION) |=> q.pg_rx)
        else $error("sticky bit lost without read");
    a_incr_both: assert property (@(posedge clk) disable iff (reset)
        e_rd && hdr[4:0] == REG_MMD_DATA && q.op == MMD_OP_INC_RW
        |=> q.mreg == $past(q.mreg) + 16'h0001)
        else $error("read did not advance address");
    a_read_noinc: assert property (@(posedge clk) disable iff (reset)
        e_rd && q.op == MMD_OP_INC_WR |=> $stable(q.mreg))
        else $error("read advanced address");
    a_data_noinc: assert property (@(posedge clk) disable iff (reset)
        (e_rd || e_wr) && q.op == MMD_OP_DATA |=> $stable(q.mreg))
        else $error("plain data access moved address");
    a_addr_load: assert property (@(posedge clk) disable iff (reset)
        e_wr && q.regad == REG_MMD_DATA && q.op == MMD_OP_ADDR
        |=> q.mreg == $past(wword) && !mmd_wr)
        else $error("address not loaded");
    a_data_write: assert property (@(posedge clk) disable iff (reset)
        e_wr && q.regad == REG_MMD_DATA && q.op != MMD_OP_ADDR
        |=> mmd_wr && mmd_wdata == $past(wword) ##1 !mmd_wr)
        else $error("data write not issued");
    a_wr_addr: assert property (@(posedge clk) disable iff (reset)
        e_wr && q.regad == REG_MMD_DATA && q.op != MMD_OP_ADDR
        |=> mmd_reg == $past(q.mreg))
        else $error("write issued at moved address");
    a_wr_incr: assert property (@(posedge clk) disable iff (reset)
        mmd_wr && q.op != MMD_OP_DATA
        |=> mmd_reg == $past(mmd_reg) + 16'h0001)
        else $error("write did not advance address");
    a_np_reset: assert property (@(posedge clk)
        reset |=> np_tx_word[NP_MSG] && np_tx_word[NP_CODE_W-1:0] == NP_CODE_RST)
        else $error("next page reset value wrong");
    a_exp_const: assert property (@(posedge clk) disable iff (reset)
        e_rd && hdr[4:0] == REG_EXPANSION |=> q.sh[EXP_NP_ABLE])
        else $error("next page able bit not set");

    c_exp_read: cover property (@(posedge clk) disable iff (reset)
        e_rd && hdr[4:0] == REG_EXPANSION && q.pg_rx);
    c_mmd_write: cover property (@(posedge clk) disable iff (reset)
        mmd_wr && q.op == MMD_OP_INC_WR);
    c_mmd_read: cover property (@(posedge clk) disable iff (reset)
        mmd_rd ##[1:200] !mdio_oe_n);

endmodule : pnm_regs

//--- pnm_mdio_host.sv
// Station management host model that runs MDC and MDIO frames.
`timescale 1ns/1ps
module pnm_mdio_host
    import pnm_pkg::*;
(
    // Management pins.
    output logic mdc,
    output logic mdio_o,
    output logic mdio_en,
    input wire logic mdio_i
);
    initial
    begin
        mdc = 1'b0;
        mdio_o = 1'b1;
        mdio_en = 1'b0;
    end

    // One MDC period; the line is sampled just before the rise.
    task automatic clk_bit(input logic b, input logic en, output logic s);
        mdio_o = b;
        mdio_en = en;
        #40;
        s = mdio_i;
        mdc = 1'b1;
        #40;
        mdc = 1'b0;
    endtask : clk_bit

    // Full frame with preamble; MDC stands still once the frame is over.
    task automatic frame(input logic rd, input logic [4:0] pa,
        input logic [4:0] ra, input logic [15:0] wd,
        output logic [15:0] rdat, output logic ta0);
        logic [45:0] hdr;
        logic s;
        hdr = {32'hffffffff, FRAME_START,
            rd ? FRAME_OP_READ : FRAME_OP_WRITE, pa, ra};
        for (int i = 45; i >= 0; i--)
            clk_bit(hdr[i], 1'b1, s);
        clk_bit(1'b1, !rd, s);
        clk_bit(1'b0, !rd, ta0);
        for (int i = 15; i >= 0; i--)
        begin
            clk_bit(wd[i], !rd, s);
            rdat[i] = s;
        end
        mdio_en = 1'b0;
        #200;
    endtask : frame
endmodule : pnm_mdio_host

//--- phy_autoneg_nextpage_mmd_regs_tb.sv
// Self-checking testbench for the management register bank.
`timescale 1ns/1ps
module phy_autoneg_nextpage_mmd_regs_tb
    import pnm_pkg::*;
;
    localparam logic [4:0] PHY_A = 5'h0b;
    logic clk, reset, mdc, host_o, host_en, mdio_out, mdio_oe_n;
    logic pf_evt, pr_evt, lp_np_able, lp_an_able, tx_toggle;
    logic mmd_wr, mmd_rd;
    logic [15:0] lp_np_word, np_tx_word, mmd_reg, mmd_wdata, mmd_rdata;
    logic [15:0] wr_reg, wr_data;
    logic [4:0] mmd_dev;
    wire logic mdio_pin;
    int bad_count, n_checks, wr_n, rd_n;

    // The line has a pull-up, so it reads high when nobody drives it.
    assign mdio_pin = !mdio_oe_n ? mdio_out : host_en ? host_o : 1'b1;

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    pnm_regs #(.PHY_ADDR(PHY_A)) i_dut (
        .clk(clk), .reset(reset), .mdc(mdc), .mdio_in(mdio_pin),
        .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
        .parallel_fault_evt(pf_evt), .page_rx_evt(pr_evt),
        .lp_np_able(lp_np_able), .lp_an_able(lp_an_able),
        .tx_toggle(tx_toggle), .lp_np_word(lp_np_word),
        .np_tx_word(np_tx_word), .mmd_dev(mmd_dev), .mmd_reg(mmd_reg),
        .mmd_wdata(mmd_wdata), .mmd_wr(mmd_wr), .mmd_rd(mmd_rd),
        .mmd_rdata(mmd_rdata));

    pnm_mdio_host i_host (
        .mdc(mdc), .mdio_o(host_o), .mdio_en(host_en), .mdio_i(mdio_pin));

    // Indirect device model: data is a fixed mix of device and address.
    always @(negedge clk)
    begin
        mmd_rdata <= 16'hc000 ^ mmd_reg ^ {mmd_dev, 11'h0};
        if (mmd_wr === 1'b1)
        begin
            wr_n++;
            wr_reg = mmd_reg;
            wr_data = mmd_wdata;
        end
        if (mmd_rd === 1'b1)
            rd_n++;
    end

    task automatic tally_and_finish;
        if (bad_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [4:0] pa, input logic [4:0] ra,
        input logic [15:0] wd);
        logic [15:0] d;
        logic t;
        i_host.frame(1'b0, pa, ra, wd, d, t);
    endtask : wr

    task automatic rd(input logic [4:0] ra, input logic [15:0] exp,
        input string what);
        logic [15:0] d;
        logic t;
        i_host.frame(1'b1, PHY_A, ra, 16'h0, d, t);
        chk("turnaround", 16'h0, {15'h0, t});
        chk(what, exp, d);
    endtask : rd

    initial
    begin
        #500000;
        bad_count++;
        tally_and_finish();
    end

    initial
    begin
        reset = 1'b1;
        pf_evt = 1'b0;
        pr_evt = 1'b0;
        lp_np_able = 1'b0;
        lp_an_able = 1'b0;
        tx_toggle = 1'b0;
        lp_np_word = 16'h0;
        repeat (12) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        rd(REG_PARTNER_BASE, 16'h0001, "partner_base");
        rd(REG_EXPANSION, 16'h0004, "expansion");
        rd(REG_LOCAL_NP, 16'h2001, "local_np");
        rd(REG_PARTNER_NP, 16'h0800, "partner_np");
        rd(REG_MMD_CTRL, 16'h0000, "mmd_ctrl");
        rd(REG_MMD_DATA, 16'h0000, "mmd_data");
        @(negedge clk);
        tx_toggle = 1'b1;
        wr(PHY_A, REG_LOCAL_NP, 16'hffff);
        rd(REG_LOCAL_NP, 16'hbfff, "local_np");
        chk("np_tx_word", 16'hbfff, np_tx_word);
        wr(PHY_A, REG_LOCAL_NP, 16'h0000);
        @(negedge clk);
        tx_toggle = 1'b0;
        rd(REG_LOCAL_NP, 16'h0000, "local_np");
        // A frame for another address and an unmapped read change nothing.
        wr(PHY_A ^ 5'h01, REG_LOCAL_NP, 16'hffff);
        rd(REG_LOCAL_NP, 16'h0000, "foreign_write");
        rd(5'h1f, 16'h0000, "unmapped");
        @(negedge clk);
        lp_np_able = 1'b1;
        lp_an_able = 1'b1;
        lp_np_word = 16'hf5a5;
        rd(REG_EXPANSION, 16'h000d, "expansion");
        @(negedge clk);
        pf_evt = 1'b1;
        pr_evt = 1'b1;
        @(negedge clk);
        pf_evt = 1'b0;
        pr_evt = 1'b0;
        lp_np_word = 16'h0;
        rd(REG_EXPANSION, 16'h001f, "expansion");
        rd(REG_EXPANSION, 16'h000d, "expansion");
        rd(REG_PARTNER_NP, 16'hfda5, "partner_np");
        @(negedge clk);
        tx_toggle = 1'b1;
        rd(REG_PARTNER_NP, 16'hf5a5, "partner_np");
        wr(PHY_A, REG_MMD_CTRL, 16'h0003);
        wr(PHY_A, REG_MMD_DATA, 16'h0010);
        rd(REG_MMD_DATA, 16'h0010, "mmd_addr");
        wr(PHY_A, REG_MMD_CTRL, 16'h7fe3);
        rd(REG_MMD_CTRL, 16'h4003, "mmd_ctrl");
        chk("mmd_dev", 16'h0003, {11'h0, mmd_dev});
        rd(REG_MMD_DATA, 16'hd810, "mmd_rdata");
        wr(PHY_A, REG_MMD_DATA, 16'h1234);
        chk("wr_reg", 16'h0010, wr_reg);
        chk("wr_data", 16'h1234, wr_data);
        chk("mmd_reg", 16'h0010, mmd_reg);
        wr(PHY_A, REG_MMD_CTRL, 16'h8003);
        rd(REG_MMD_DATA, 16'hd810, "mmd_rdata");
        rd(REG_MMD_DATA, 16'hd811, "mmd_rdata");
        wr(PHY_A, REG_MMD_DATA, 16'h5678);
        chk("wr_reg", 16'h0012, wr_reg);
        chk("wr_data", 16'h5678, wr_data);
        wr(PHY_A, REG_MMD_CTRL, 16'hc003);
        rd(REG_MMD_DATA, 16'hd813, "mmd_rdata");
        rd(REG_MMD_DATA, 16'hd813, "mmd_rdata");
        chk("mmd_reg", 16'h0013, mmd_reg);
        wr(PHY_A, REG_MMD_DATA, 16'h9abc);
        chk("mmd_reg", 16'h0014, mmd_reg);
        chk("wr_data", 16'h9abc, wr_data);
        chk("wr_reg", 16'h0013, wr_reg);
        wr(PHY_A, REG_MMD_CTRL, 16'h0003);
        rd(REG_MMD_DATA, 16'h0014, "mmd_addr");
        chk("wr_count", 16'h0003, 16'(wr_n));
        chk("rd_count", 16'h0005, 16'(rd_n));
        // A second reset drops a pending fault event and restores defaults.
        @(negedge clk);
        pf_evt = 1'b1;
        reset = 1'b1;
        @(negedge clk);
        pf_evt = 1'b0;
        @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        rd(REG_EXPANSION, 16'h000d, "expansion_rst");
        rd(REG_LOCAL_NP, 16'h2801, "local_np_rst");
        rd(REG_PARTNER_NP, 16'h0000, "partner_np_rst");
        rd(REG_MMD_CTRL, 16'h0000, "mmd_ctrl_rst");
        rd(REG_MMD_DATA, 16'h0000, "mmd_addr_rst");
        tally_and_finish();
    end
endmodule : phy_autoneg_nextpage_mmd_regs_tb
